// file: liucl_pkg.sv
// Constants for the line interface change-latch block.
// Assumes a single hclk domain and an AHB-Lite register port.
package liucl_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] LIUCL_ENABLE_OFS = 8'h00; // Interrupt enable (mask)
    localparam logic [7:0] LIUCL_LIVE_OFS = 8'h04; // Live status
    localparam logic [7:0] LIUCL_STATUS_OFS = 8'h08; // Sticky change latches
    localparam logic [7:0] LIUCL_CONTROL_OFS = 8'h0C; // Single-rail mode control
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LIUCL_DRIVE_BIT = 6;
    localparam int LIUCL_FIFO_BIT = 5;
    localparam int LIUCL_LCV_BIT = 4;
    localparam int LIUCL_LOOP_BIT = 3;
    localparam int LIUCL_RAIL_BIT = 0;
    localparam logic [7:0] LIUCL_FIELD_MASK = 8'h78; // Bits 6..3 in use
    localparam logic [7:0] LIUCL_WCLR_MASK = 8'h68; // Latches that a written one also clears
    // ------------------------------------------------------------
    // Reset values and the AHB-Lite NONSEQ transfer code
    // ------------------------------------------------------------
    localparam logic [7:0] LIUCL_LATCH_RST = 8'h00;
    localparam logic [7:0] LIUCL_ENABLE_RST = 8'h00;
    localparam logic [7:0] LIUCL_CONTROL_RST = 8'h00;
    localparam logic [1:0] LIUCL_HTRANS_NONSEQ = 2'h2;
endpackage : liucl_pkg

// file: liucl_sync_if.sv
// Interface carrying the synchronised live conditions.
// Assumes producer and consumer share hclk.
`timescale 1ns/1ps
`default_nettype none
interface liucl_sync_if;
    logic [7:0] live; // Live conditions at their register positions
    logic [7:0] change; // One-cycle pulse per bit on any change
    modport src (output live, output change);
    modport dst (input live, input change);
endinterface : liucl_sync_if
`default_nettype wire

// file: liucl_sync.sv
// Two-flop synchroniser and change detector for the live conditions.
// Assumes raw inputs are asynchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module liucl_sync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] raw,
    liucl_sync_if.src sy
);
    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    logic [7:0] meta_q; // First stage, read only by stage two
    logic [7:0] sync_q; // Second stage, safe to use
    logic [7:0] prev_q; // Last value, for change detection

    // Three-stage shift; edge detector looks only past stage one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
            prev_q <= 8'h00;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign sy.live = sync_q;
    assign sy.change = sync_q ^ prev_q; // Either direction counts
endmodule : liucl_sync
`default_nettype wire

// file: liucl_top.sv
// Top of the line interface change-latch block with AHB-Lite port.
// Assumes one clock; live conditions arrive on asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module liucl_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic drive_monitor_output,
    input wire logic fifo_limit_in,
    input wire logic line_code_violation_in,
    input wire logic loop_code_in,
    output logic irq
);
    // ------------------------------------------------------------
    // Synchronised live conditions
    // ------------------------------------------------------------
    liucl_sync_if sy ();
    logic [7:0] raw; // Pins placed at their register positions

    assign raw = {1'b0, drive_monitor_output, fifo_limit_in,
                  line_code_violation_in, loop_code_in, 3'h0};

    liucl_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw(raw),
        .sy(sy)
    );

    // ------------------------------------------------------------
    // AHB-Lite address phase capture
    // ------------------------------------------------------------
    logic ph_wr_q; // Write data phase pending
    logic ph_rd_q; // Read data phase pending
    logic [7:0] ph_addr_q; // Captured address
    logic addr_ok; // Valid transfer this cycle

    assign addr_ok = hsel && hready && (htrans == liucl_pkg::LIUCL_HTRANS_NONSEQ);

    // Capture one address phase; slave always zero wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_q <= 1'b0;
            ph_rd_q <= 1'b0;
            ph_addr_q <= 8'h00;
        end else begin
            ph_wr_q <= addr_ok && hwrite;
            ph_rd_q <= addr_ok && !hwrite;
            ph_addr_q <= addr_ok ? haddr : ph_addr_q;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    logic rd_status; // Status read: clears latches on the same edge
    logic wr_status; // Status write: clears latches where a one is written, except the violation latch
    logic wr_enable;
    logic wr_control;
    logic rd_status_a; // Status read seen in address phase

    assign rd_status_a = addr_ok && !hwrite && hit(haddr, liucl_pkg::LIUCL_STATUS_OFS);
    assign rd_status = rd_status_a;
    assign wr_status = ph_wr_q && hit(ph_addr_q, liucl_pkg::LIUCL_STATUS_OFS);
    assign wr_enable = ph_wr_q && hit(ph_addr_q, liucl_pkg::LIUCL_ENABLE_OFS);
    assign wr_control = ph_wr_q && hit(ph_addr_q, liucl_pkg::LIUCL_CONTROL_OFS);

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [7:0] enable_q; // Interrupt enable mask
    logic [7:0] control_q; // Bit 0: single-rail mode
    logic single_rail; // Block active only in single-rail mode

    assign single_rail = control_q[liucl_pkg::LIUCL_RAIL_BIT];

    // Mask and mode registers, written in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q <= liucl_pkg::LIUCL_ENABLE_RST;
            control_q <= liucl_pkg::LIUCL_CONTROL_RST;
        end else begin
            if (wr_enable) begin
                enable_q <= hwdata[7:0] & liucl_pkg::LIUCL_FIELD_MASK;
            end
            if (wr_control) begin
                control_q <= {7'h00, hwdata[liucl_pkg::LIUCL_RAIL_BIT]};
            end
        end
    end

    // ------------------------------------------------------------
    // Change latches
    // ------------------------------------------------------------
    logic [7:0] latch_q; // Sticky change latches
    logic [7:0] latch_d;
    logic [7:0] set_v; // Changes that set latches
    logic [7:0] clr_v; // Bits cleared this cycle
    logic [7:0] wclr_v; // Written ones, limited to latches that allow a write clear

    // Change on any live bit sets its latch, only in single-rail mode
    assign set_v = single_rail ? (sy.change & liucl_pkg::LIUCL_FIELD_MASK) :
                   8'h00;
    // The violation latch clears on read only, so a written one leaves it alone
    assign wclr_v = hwdata[7:0] & liucl_pkg::LIUCL_WCLR_MASK;
    // Read clears all; a write clears where ones are written, except the violation latch
    assign clr_v = rd_status ? 8'hFF : (wr_status ? wclr_v : 8'h00);
    // Set wins over clear so no change is lost
    assign latch_d = (latch_q & ~clr_v) | set_v;

    // Latches reset to zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_q <= liucl_pkg::LIUCL_LATCH_RST;
        end else begin
            latch_q <= latch_d;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] live_v; // Live state, gated by single-rail mode
    logic [7:0] rd_v; // Address-phase selection, captured for the data phase

    assign live_v = single_rail ? (sy.live & liucl_pkg::LIUCL_FIELD_MASK) :
                    8'h00;
    // Status answers with the latches as they stand before this edge's clear
    assign rd_v = hit(haddr, liucl_pkg::LIUCL_ENABLE_OFS) ? enable_q :
                  hit(haddr, liucl_pkg::LIUCL_LIVE_OFS) ? live_v :
                  hit(haddr, liucl_pkg::LIUCL_STATUS_OFS) ? latch_q :
                  hit(haddr, liucl_pkg::LIUCL_CONTROL_OFS) ? control_q :
                  8'h00; // Unmapped reads zero

    // Read data held in a flop, driven while the read phase lasts
    logic [31:0] hrdata_q;
    logic irq_q;

    // Capture read data one cycle after address so data phase sees it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(latch_d & enable_q);
            hrdata_q <= 32'h0000_0000;
            if (addr_ok && !hwrite) begin
                hrdata_q <= {24'h00_0000, rd_v};
            end
        end
    end

    logic unused_ok; // Only whole words are served, so hsize is not decoded
    assign unused_ok = ph_rd_q ^ (|hsize);

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic hreadyout_q;
    logic hresp_q; // Error response is never given
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1; // Zero wait state, always OKAY
            hresp_q <= 1'b0;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign irq = irq_q;
endmodule : liucl_top
`default_nettype wire

// file: liucl_props.sv
// Bus and latch assertions for liucl_top, bound in from the bench.
// Assumes one hclk domain and a bus with no wait states.
`timescale 1ns/1ps
`default_nettype none
module liucl_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic drive_monitor_output,
    input wire logic fifo_limit_in,
    input wire logic line_code_violation_in,
    input wire logic loop_code_in,
    input wire logic irq
);
    logic rd_q, wr_q, rail_q; // Data phase kinds, shadow of single-rail bit
    logic [7:0] ofs_q, en_q; // Data phase offset, shadow of the mask
    logic [3:0] pin_q; // Pins one cycle ago
    logic [2:0] sc_q; // Quiet cycles on the pins, saturating
    wire logic [3:0] pin_w = {drive_monitor_output, fifo_limit_in, line_code_violation_in,
        loop_code_in};
    wire logic take_w = hsel && hready && htrans == 2'h2;
    wire logic chg_w = pin_w != pin_q;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Shadow state; the mask is tracked so a change is only expected on irq when unmasked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            ofs_q <= 8'h00;
            rail_q <= 1'b0;
            en_q <= 8'h00;
            pin_q <= 4'h0;
            sc_q <= 3'h0;
        end else begin
            rd_q <= take_w && !hwrite;
            wr_q <= take_w && hwrite;
            ofs_q <= haddr;
            if (wr_q && ofs_q == 8'h0C) rail_q <= hwdata[0];
            if (wr_q && ofs_q == 8'h00) en_q <= hwdata[7:0];
            pin_q <= pin_w;
            sc_q <= chg_w ? 3'h0 : (sc_q == 3'h7 ? sc_q : sc_q + 3'h1);
        end
    end
    // Status read with the pins quiet long enough that no set is in flight
    sequence st_rd;
        rd_q && ofs_q == 8'h08 && sc_q > 3'h5;
    endsequence
    AST_READY: assert property (hreadyout) else $error("hreadyout dropped");
    AST_OKAY: assert property (!hresp) else $error("response not OKAY");
    AST_RDATA_IDLE: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("hrdata outside read data phase");
    AST_UPPER_ZERO: assert property (rd_q |-> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_LIVE:
        assert property (rd_q && ofs_q == 8'h04 && rail_q && sc_q > 3'h4
            |-> hrdata[7:0] == {1'b0, pin_w, 3'h0}) else $error("live bits differ from pins");
    AST_LIVE_OFF:
        assert property (rd_q && ofs_q == 8'h04 && !rail_q |-> hrdata == 32'h0)
        else $error("live bits shown in idle mode");
    AST_CLEAR: assert property (st_rd ##2 st_rd |-> hrdata[7:0] == 8'h00)
        else $error("latch survived a status read");
    AST_IRQ_DROP: assert property (st_rd |-> ##1 !irq) else $error("irq after clear");
    AST_SET:
        assert property (chg_w && rail_q && en_q[6:3] == 4'hF |-> ##[1:8] irq)
        else $error("pin change raised no interrupt");
endmodule // liucl_props
`default_nettype wire

// file: liu_change_interrupt_latches_tb.sv
// Self-checking bench for liucl_top over its AHB-Lite port.
// Assumes the design files and liucl_props are compiled first.
`timescale 1ns/1ps
`default_nettype none
module liu_change_interrupt_latches_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd_s;
    logic hreadyout, hresp, irq;
    logic [3:0] pins = 4'h0; // Condition pins, drive monitor at the top
    logic [3:0] cur, chg; // Expected live state and last change
    int err_count = 0, n_tests = 0, seed = 87;
    always #2.5 hclk = ~hclk; // 200 MHz
    liucl_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .drive_monitor_output(pins[3]),
        .fifo_limit_in(pins[2]), .line_code_violation_in(pins[1]), .loop_code_in(pins[0]),
        .irq(irq));
    // Places the four conditions at their register bits
    function automatic logic [31:0] at_pos(input logic [3:0] v);
        return {25'h0, v, 3'h0};
    endfunction
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Samples hready and read data at the rising edge, before the slave's update lands
    task automatic step();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            err_count++;
            complete_run();
        end else begin
            rd_s = hrdata;
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        step();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        step();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(rd_s, exp);
    endtask
    // Interrupt level, looked at mid-cycle where it is settled
    task automatic irq_is(input logic e);
        @(negedge hclk);
        n_tests++;
        if (irq !== e) begin
            err_count++;
            $display("FAIL %0t irq %b expected %b", $time, irq, e);
        end
        @(posedge hclk);
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0);
        bus(8'h10, 1'b1, 32'hFFFFFFFF);
        rd(8'h10, 32'h0);
        $display("test reset_values done");
        pins <= 4'hF;
        repeat (8) @(posedge hclk);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        $display("test rail_off done");
        bus(8'h0C, 1'b1, 32'h1);
        bus(8'h00, 1'b1, 32'h78);
        cur = 4'hF;
        repeat (8) @(posedge hclk);
        bus(8'h08, 1'b0, 32'h0);
        // First pass flips every pin at once, then random patterns, zero included
        for (int i = 0; i < 16; i++) begin
            chg = (i == 0) ? 4'hF : 4'($random(seed));
            cur = cur ^ chg;
            pins <= cur;
            repeat (8) @(posedge hclk);
            irq_is(chg != 4'h0);
            rd(8'h04, at_pos(cur));
            rd(8'h08, at_pos(chg));
            rd(8'h08, 32'h0);
        end
        $display("test random_changes done");
        bus(8'h00, 1'b1, 32'h0);
        pins <= cur ^ 4'h8;
        repeat (8) @(posedge hclk);
        irq_is(1'b0);
        bus(8'h00, 1'b1, 32'h40);
        repeat (2) @(posedge hclk);
        irq_is(1'b1);
        bus(8'h08, 1'b1, 32'h40);
        repeat (2) @(posedge hclk);
        irq_is(1'b0);
        rd(8'h08, 32'h0);
        // Violation latch clears on read only: a written one must leave it set
        pins <= cur ^ 4'hA;
        repeat (8) @(posedge hclk);
        bus(8'h08, 1'b1, 32'h10);
        rd(8'h08, 32'h10);
        $display("test mask_clear done");
        complete_run();
    end
endmodule // liu_change_interrupt_latches_tb
bind liucl_top liucl_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .drive_monitor_output(drive_monitor_output), .fifo_limit_in(fifo_limit_in),
    .line_code_violation_in(line_code_violation_in), .loop_code_in(loop_code_in));
`default_nettype wire
